// ---- shared/abtas_regs.svh ----
// Named positions, limits and reset values of the telegram and address logic.
// Assumes inclusion by bare name from any file that decodes the telegrams.
`ifndef ABTAS_REGS_SVH
`define ABTAS_REGS_SVH
// Stored address value that means no valid address.
`define ABTAS_ADDR_INVALID 8'hFF
// Highest motor current figure, 800 percent.
`define ABTAS_PCT_MAX 16'h0320
// Bit positions of the first command byte.
`define ABTAS_C0_FAULT_RESET 6
`define ABTAS_C0_AUTO 5
`define ABTAS_C0_PREP_EMERG 4
`define ABTAS_C0_OPEN 2
`define ABTAS_C0_OFF 1
`define ABTAS_C0_CLOSE 0
// Bit positions of the second command byte.
`define ABTAS_C1_DO2 7
`define ABTAS_C1_AUX 4
// Reset values of output registers.
`define ABTAS_BYTE_RST 8'h00
`define ABTAS_WORD_RST 16'h0000
// Reset value of the six decoded command bits.
`define ABTAS_CMD_RST 6'h00
`endif

// ---- shared/abtas_pkg.sv ----
// Types used by the bus address agreement logic.
// Assumes nothing of its surroundings.
package abtas_pkg;
	// Phases of the bus address agreement.
	typedef enum logic [2:0] {
		ST_LOAD,
		ST_WAIT,
		ST_DECIDE,
		ST_SILENT,
		ST_FAULT,
		ST_RUN
	} abtas_state_t;
endpackage : abtas_pkg

// ---- design/abtas_top.sv ----
// Actuator-mode process data packing and bus address agreement with the adapter plug.
// Assumes all inputs synchronous to CLOCK, and nonvolatile store and plug act on pulses.
`include "abtas_regs.svh"
module abtas_top (
	// Clock and reset.
	input wire logic CLOCK,
	input wire logic RSTN,
	// Actuator status for monitor byte 0.
	input wire logic STS_WARNING,
	input wire logic STS_FAULT,
	input wire logic STS_LOCAL,
	input wire logic STS_LOCKOUT,
	input wire logic STS_OVERLOAD,
	input wire logic STS_OPENING,
	input wire logic STS_OFF,
	input wire logic STS_CLOSING,
	// On-board inputs, bit n is digital_input_zero upward.
	input wire logic [5:0] DIGITAL_INPUTS,
	// Motor current in percent of rated_operating_current.
	input wire logic [15:0] CURRENT_PCT,
	// Command bytes from the master.
	input wire logic [7:0] CMD_BYTE0,
	input wire logic [7:0] CMD_BYTE1,
	// Fault output configuration and the internal fault level.
	input wire logic DO2_IS_FAULT,
	input wire logic AUX_IS_FAULT,
	input wire logic FAULT_ACTIVE,
	// Address sources.
	input wire logic [7:0] NV_ADDR_IN,
	input wire logic PANEL_WR,
	input wire logic [7:0] PANEL_ADDR,
	input wire logic PANEL_FIX,
	input wire logic PLUG_PRESENT,
	input wire logic [7:0] PLUG_ADDR,
	input wire logic ADDR_CHECK_EN,
	// Monitoring telegram.
	output logic [7:0] MON_BYTE0,
	output logic [7:0] MON_BYTE1,
	output logic [15:0] MON_WORD1,
	// Decoded commands.
	output logic CMD_FAULT_RESET,
	output logic CMD_AUTO,
	output logic CMD_PREP_EMERG,
	output logic CMD_OPEN,
	output logic CMD_OFF,
	output logic CMD_CLOSE,
	output logic DIGITAL_OUTPUT_TWO,
	output logic AUX_SUPPLY_OUTPUT,
	// Address agreement results.
	output logic [7:0] CTRL_ADDR,
	output logic NV_WR,
	output logic PLUG_WR,
	output logic BUS_ENABLE,
	output logic ADDR_FAULT
);

	// True when an address is usable on the bus.
	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a != `ABTAS_ADDR_INVALID);
	endfunction : addr_ok

	// Telegram registers and their next values.
	logic [7:0] mon0_r, mon0_nxt;
	logic [7:0] mon1_r, mon1_nxt;
	logic [15:0] mon2_r, mon2_nxt;
	logic [5:0] cmd_r, cmd_nxt;
	logic do2_r, do2_nxt;
	logic aux_r, aux_nxt;

	// Address registers and their next values.
	abtas_pkg::abtas_state_t st_r, st_nxt;
	logic [7:0] addr_r, addr_nxt;
	logic nvwr_r, nvwr_nxt;
	logic plwr_r, plwr_nxt;
	logic bus_r, bus_nxt;
	logic flt_r, flt_nxt;

	// Telegram packing and command decoding.
	always_comb begin
		mon0_nxt = {STS_WARNING, STS_FAULT, STS_LOCAL, STS_LOCKOUT,
			STS_OVERLOAD, STS_OPENING, STS_OFF, STS_CLOSING};
		// The two unused low bits read as zero.
		mon1_nxt = {DIGITAL_INPUTS, 2'b00};
		// Saturate so a sensor glitch never reports past the scale end.
		if (CURRENT_PCT > `ABTAS_PCT_MAX) begin
			mon2_nxt = `ABTAS_PCT_MAX;
		end else begin
			mon2_nxt = CURRENT_PCT;
		end
		// Unused command bits 7 and 3 are simply not decoded.
		cmd_nxt = {CMD_BYTE0[`ABTAS_C0_FAULT_RESET], CMD_BYTE0[`ABTAS_C0_AUTO],
			CMD_BYTE0[`ABTAS_C0_PREP_EMERG], CMD_BYTE0[`ABTAS_C0_OPEN],
			CMD_BYTE0[`ABTAS_C0_OFF], CMD_BYTE0[`ABTAS_C0_CLOSE]};
		// A fault output follows the fault level, not the master.
		if (DO2_IS_FAULT) begin
			do2_nxt = FAULT_ACTIVE;
		end else begin
			do2_nxt = CMD_BYTE1[`ABTAS_C1_DO2];
		end
		if (AUX_IS_FAULT) begin
			aux_nxt = FAULT_ACTIVE;
		end else begin
			aux_nxt = CMD_BYTE1[`ABTAS_C1_AUX];
		end
	end

	// Telegram registers.
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			mon0_r <= `ABTAS_BYTE_RST;
			mon1_r <= `ABTAS_BYTE_RST;
			mon2_r <= `ABTAS_WORD_RST;
			cmd_r <= `ABTAS_CMD_RST;
			do2_r <= 1'b0;
			aux_r <= 1'b0;
		end else begin
			mon0_r <= mon0_nxt;
			mon1_r <= mon1_nxt;
			mon2_r <= mon2_nxt;
			cmd_r <= cmd_nxt;
			do2_r <= do2_nxt;
			aux_r <= aux_nxt;
		end
	end

	// Address agreement. The stored address is caught in the first cycle after
	// reset release, since a port value may not enter the reset branch.
	always_comb begin
		st_nxt = st_r;
		addr_nxt = addr_r;
		nvwr_nxt = 1'b0;
		plwr_nxt = 1'b0;
		bus_nxt = bus_r;
		flt_nxt = flt_r;
		case (st_r)
			abtas_pkg::ST_LOAD: begin
				// Any value 0 to 255 is taken as stored.
				addr_nxt = NV_ADDR_IN;
				st_nxt = abtas_pkg::ST_WAIT;
			end
			abtas_pkg::ST_WAIT: begin
				// Without a plug there is nothing to compare against.
				if (PLUG_PRESENT) begin
					st_nxt = abtas_pkg::ST_DECIDE;
				end
			end
			abtas_pkg::ST_DECIDE: begin
				if (!addr_ok(addr_r) && !addr_ok(PLUG_ADDR)) begin
					st_nxt = abtas_pkg::ST_SILENT;
					bus_nxt = 1'b0;
				end else if (!addr_ok(addr_r)) begin
					// Adopt and store the plug address, then start.
					addr_nxt = PLUG_ADDR;
					nvwr_nxt = 1'b1;
					st_nxt = abtas_pkg::ST_RUN;
					bus_nxt = 1'b1;
				end else if (!addr_ok(PLUG_ADDR)) begin
					// The full value goes out, so it also carries the baud choice.
					plwr_nxt = 1'b1;
					st_nxt = abtas_pkg::ST_RUN;
					bus_nxt = 1'b1;
				end else if (addr_r == PLUG_ADDR) begin
					st_nxt = abtas_pkg::ST_RUN;
					bus_nxt = 1'b1;
				end else if (!ADDR_CHECK_EN) begin
					plwr_nxt = 1'b1;
					st_nxt = abtas_pkg::ST_RUN;
					bus_nxt = 1'b1;
				end else begin
					// Mismatch with check on: the drawer may be in the wrong slot.
					st_nxt = abtas_pkg::ST_FAULT;
					bus_nxt = 1'b0;
					flt_nxt = 1'b1;
				end
			end
			abtas_pkg::ST_FAULT: begin
				if (PANEL_FIX) begin
					// Fix takes the plug address and stores it in the nonvolatile store only.
					addr_nxt = PLUG_ADDR;
					nvwr_nxt = 1'b1;
					flt_nxt = 1'b0;
					bus_nxt = 1'b1;
					st_nxt = abtas_pkg::ST_RUN;
				end else if (PANEL_WR) begin
					addr_nxt = PANEL_ADDR;
					nvwr_nxt = 1'b1;
					flt_nxt = 1'b0;
					st_nxt = abtas_pkg::ST_WAIT;
				end
			end
			abtas_pkg::ST_SILENT, abtas_pkg::ST_RUN: begin
				// A new panel entry stops the bus and agrees afresh.
				if (PANEL_WR) begin
					addr_nxt = PANEL_ADDR;
					nvwr_nxt = 1'b1;
					bus_nxt = 1'b0;
					st_nxt = abtas_pkg::ST_WAIT;
				end else if (!PLUG_PRESENT) begin
					// A removed plug ends communication until it returns.
					bus_nxt = 1'b0;
					st_nxt = abtas_pkg::ST_WAIT;
				end
			end
			default: begin
				st_nxt = abtas_pkg::ST_LOAD;
				bus_nxt = 1'b0;
				flt_nxt = 1'b0;
			end
		endcase
	end

	// Address registers.
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			st_r <= abtas_pkg::ST_LOAD;
			addr_r <= `ABTAS_ADDR_INVALID;
			nvwr_r <= 1'b0;
			plwr_r <= 1'b0;
			bus_r <= 1'b0;
			flt_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			addr_r <= addr_nxt;
			nvwr_r <= nvwr_nxt;
			plwr_r <= plwr_nxt;
			bus_r <= bus_nxt;
			flt_r <= flt_nxt;
		end
	end

	// Outputs straight from the registers.
	assign MON_BYTE0 = mon0_r;
	assign MON_BYTE1 = mon1_r;
	assign MON_WORD1 = mon2_r;
	assign {CMD_FAULT_RESET, CMD_AUTO, CMD_PREP_EMERG, CMD_OPEN, CMD_OFF, CMD_CLOSE} = cmd_r;
	assign DIGITAL_OUTPUT_TWO = do2_r;
	assign AUX_SUPPLY_OUTPUT = aux_r;
	assign CTRL_ADDR = addr_r;
	assign NV_WR = nvwr_r;
	assign PLUG_WR = plwr_r;
	assign BUS_ENABLE = bus_r;
	assign ADDR_FAULT = flt_r;

	// Checks on the telegram and on the agreement.
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RSTN);

	// Telegram checks skip the first edge after reset, where the registers still hold
	// reset values while the sampled history holds the inputs seen during reset.
	AST_MON0: assert property ($past(RSTN) |->
		MON_BYTE0 == $past({STS_WARNING, STS_FAULT, STS_LOCAL, STS_LOCKOUT,
		STS_OVERLOAD, STS_OPENING, STS_OFF, STS_CLOSING}))
		else $error("Monitor byte 0 wrong.");
	AST_MON1: assert property ($past(RSTN) |->
		MON_BYTE1 == {$past(DIGITAL_INPUTS), 2'b00})
		else $error("Monitor byte 1 wrong.");
	AST_CUR: assert property ($past(RSTN) |->
		MON_WORD1 == (($past(CURRENT_PCT) > `ABTAS_PCT_MAX) ? `ABTAS_PCT_MAX :
		$past(CURRENT_PCT)))
		else $error("Current word out of range.");
	AST_CMD: assert property ($past(RSTN) |->
		{CMD_FAULT_RESET, CMD_AUTO, CMD_PREP_EMERG, CMD_OPEN, CMD_OFF, CMD_CLOSE} ==
		{$past(CMD_BYTE0[`ABTAS_C0_FAULT_RESET]), $past(CMD_BYTE0[`ABTAS_C0_AUTO]),
		$past(CMD_BYTE0[`ABTAS_C0_PREP_EMERG]), $past(CMD_BYTE0[`ABTAS_C0_OPEN]),
		$past(CMD_BYTE0[`ABTAS_C0_OFF]), $past(CMD_BYTE0[`ABTAS_C0_CLOSE])})
		else $error("Command decode wrong.");
	AST_DO2: assert property ($past(RSTN) |->
		DIGITAL_OUTPUT_TWO == ($past(DO2_IS_FAULT) ? $past(FAULT_ACTIVE) :
		$past(CMD_BYTE1[`ABTAS_C1_DO2])))
		else $error("Output two does not follow its source.");
	AST_AUX: assert property ($past(RSTN) |->
		AUX_SUPPLY_OUTPUT == ($past(AUX_IS_FAULT) ? $past(FAULT_ACTIVE) :
		$past(CMD_BYTE1[`ABTAS_C1_AUX])))
		else $error("Aux output does not follow its source.");
	AST_SILENT: assert property (st_r == abtas_pkg::ST_DECIDE &&
		!addr_ok(addr_r) && !addr_ok(PLUG_ADDR) |=> !BUS_ENABLE && !NV_WR && !PLUG_WR)
		else $error("Bus started with no address.");
	AST_ADOPT: assert property (st_r == abtas_pkg::ST_DECIDE &&
		!addr_ok(addr_r) && addr_ok(PLUG_ADDR) |=>
		NV_WR && BUS_ENABLE && CTRL_ADDR == $past(PLUG_ADDR))
		else $error("Plug address not adopted.");
	AST_PUSH: assert property (st_r == abtas_pkg::ST_DECIDE &&
		addr_ok(addr_r) && addr_r != PLUG_ADDR && (!addr_ok(PLUG_ADDR) || !ADDR_CHECK_EN)
		|=> PLUG_WR && BUS_ENABLE && $stable(CTRL_ADDR))
		else $error("Plug not given address.");
	// A blank plug is given the controller address in the starting cycle, so it is
	// left out here: the addresses only agree one edge later.
	AST_BLOCK: assert property (BUS_ENABLE && PLUG_PRESENT && $past(ADDR_CHECK_EN) &&
		$past(st_r) == abtas_pkg::ST_DECIDE && $past(PLUG_ADDR) != `ABTAS_ADDR_INVALID
		|-> CTRL_ADDR == $past(PLUG_ADDR))
		else $error("Started on mismatch with check on.");
	AST_FAULT: assert property (ADDR_FAULT |-> !BUS_ENABLE)
		else $error("Bus on during address fault.");
	AST_FIX: assert property (st_r == abtas_pkg::ST_FAULT && PANEL_FIX |=>
		!ADDR_FAULT && BUS_ENABLE && NV_WR ##1 !NV_WR)
		else $error("Fix did not recover.");
	AST_SAME: assert property (st_r == abtas_pkg::ST_DECIDE && addr_ok(addr_r) &&
		addr_r == PLUG_ADDR |=> BUS_ENABLE && !PLUG_WR && !NV_WR)
		else $error("Equal addresses did not start.");

	CV_FAULT: cover property (ADDR_FAULT ##[1:20] BUS_ENABLE);
	CV_ADOPT: cover property (NV_WR && BUS_ENABLE);
	CV_PUSH: cover property (PLUG_WR);
	CV_SILENT: cover property (st_r == abtas_pkg::ST_SILENT);

endmodule : abtas_top

// ---- sim/abtas_plug_model.sv ----
// Behavioural adapter plug model that keeps the bus address seen by the master.
// Assumes CTRL_ADDR is valid in the cycle in which the controller pulses its write.
module abtas_plug_model (
	// Clock and bench control.
	input wire logic clock,
	input wire logic load,
	input wire logic [7:0] load_addr,
	input wire logic attach,
	// Controller side.
	input wire logic wr,
	input wire logic [7:0] wr_addr,
	output logic present,
	output logic [7:0] addr
);
	timeunit 1ns;
	timeprecision 1ps;
	// Persistent address; it survives controller resets as a real plug does.
	logic [7:0] stored_r = 8'hFF;
	// The whole byte is kept, so a serial plug can derive its baud rate from it.
	always @(posedge clock) begin
		if (load) begin
			stored_r <= load_addr;
		end else if (wr && attach) begin
			stored_r <= wr_addr;
		end
	end
	// A detached plug no longer shows its address, so the lines carry the inverse.
	assign present = attach;
	assign addr = attach ? stored_r : ~stored_r;
endmodule : abtas_plug_model

// ---- sim/test_actuator_bus_telegram_address_sync.sv ----
// Self-checking bench for telegram packing and bus address agreement.
// Assumes the design and the plug model are compiled before this file.
module test_actuator_bus_telegram_address_sync;
	timeunit 1ns;
	timeprecision 1ps;
	// Clock, reset and stimulus.
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] sts = 8'h00;
	logic [5:0] di = 6'h00;
	logic [15:0] cur = 16'h0000;
	logic [7:0] cmd0 = 8'h00;
	logic [7:0] cmd1 = 8'h00;
	logic do2f = 1'b0, auxf = 1'b0, fa = 1'b0, pwr = 1'b0, fix = 1'b0, chk = 1'b0;
	logic [7:0] nv = 8'hFF, paddr = 8'h00, pinit = 8'hFF;
	logic pload = 1'b0, attach = 1'b1, present;
	logic [7:0] plug_addr;
	// Design outputs.
	logic [7:0] mb0, mb1, caddr;
	logic [15:0] mw1;
	logic fr, au, pe, op, of, cl, do2, aux, nv_wr, plug_wr, bus, afault;
	int miscompares = 0, comparisons = 0, cycles = 0, nv_count = 0;
	abtas_top abtas_top_inst (.CLOCK(clock), .RSTN(rstn), .STS_WARNING(sts[7]),
		.STS_FAULT(sts[6]), .STS_LOCAL(sts[5]), .STS_LOCKOUT(sts[4]), .STS_OVERLOAD(sts[3]),
		.STS_OPENING(sts[2]), .STS_OFF(sts[1]), .STS_CLOSING(sts[0]), .DIGITAL_INPUTS(di),
		.CURRENT_PCT(cur), .CMD_BYTE0(cmd0), .CMD_BYTE1(cmd1), .DO2_IS_FAULT(do2f),
		.AUX_IS_FAULT(auxf), .FAULT_ACTIVE(fa), .NV_ADDR_IN(nv), .PANEL_WR(pwr),
		.PANEL_ADDR(paddr), .PANEL_FIX(fix), .PLUG_PRESENT(present), .PLUG_ADDR(plug_addr),
		.ADDR_CHECK_EN(chk), .MON_BYTE0(mb0), .MON_BYTE1(mb1), .MON_WORD1(mw1),
		.CMD_FAULT_RESET(fr), .CMD_AUTO(au), .CMD_PREP_EMERG(pe), .CMD_OPEN(op),
		.CMD_OFF(of), .CMD_CLOSE(cl), .DIGITAL_OUTPUT_TWO(do2), .AUX_SUPPLY_OUTPUT(aux),
		.CTRL_ADDR(caddr), .NV_WR(nv_wr), .PLUG_WR(plug_wr), .BUS_ENABLE(bus),
		.ADDR_FAULT(afault));
	abtas_plug_model abtas_plug_model_inst (.clock(clock), .load(pload), .load_addr(pinit),
		.attach(attach), .wr(plug_wr), .wr_addr(caddr), .present(present), .addr(plug_addr));
	// Free-running 50 MHz clock.
	initial begin
		forever #10 clock = ~clock;
	end
	// Nonvolatile writes are counted so each case can expect an exact number.
	always @(posedge clock) begin
		cycles++;
		if (nv_wr === 1'b1) nv_count++;
		if (cycles >= 5000) begin
			miscompares++;
			results();
		end
	end
	// Compares one bit.
	task automatic chk1(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: bit %b, expected %b", $time, got, exp);
		end
	endtask : chk1
	// Compares a byte or a word, zero extended.
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %h, expected %h", $time, got, exp);
		end
	endtask : chk16
	// Lets the design sample the inputs, then waits until its outputs settle.
	task automatic settle;
		@(posedge clock);
		#1;
	endtask : settle
	// Resets the controller with given stored addresses and checks the agreed outcome.
	task automatic acase(input logic [7:0] n, input logic [7:0] p, input logic c,
		input logic eb, input logic ef, input logic [7:0] ea, input logic [7:0] ep, input int en);
		@(posedge clock);
		rstn <= 1'b0;
		nv <= n;
		pinit <= p;
		pload <= 1'b1;
		chk <= c;
		@(posedge clock);
		pload <= 1'b0;
		nv_count = 0;
		@(posedge clock);
		rstn <= 1'b1;
		repeat (5) settle();
		chk1(bus, eb);
		chk1(afault, ef);
		chk16({8'h00, caddr}, {8'h00, ea});
		chk16({8'h00, plug_addr}, {8'h00, ep});
		chk16(16'(nv_count), 16'(en));
	endtask : acase
	// Prints the counts and the verdict, then ends the run.
	task automatic results;
		$display("comparisons %0d, miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : results
	// Main sequence.
	initial begin
		repeat (3) @(posedge clock);
		rstn <= 1'b1;
		// Walking ones over status, inputs and command byte 0.
		for (int i = 0; i < 8; i++) begin
			@(posedge clock);
			sts <= 8'h01 << i;
			di <= 6'h01 << (i % 6);
			cmd0 <= 8'h01 << i;
			settle();
			chk16({8'h00, mb0}, 16'h0001 << i);
			chk16({8'h00, mb1}, 16'h0004 << (i % 6));
			chk16({8'h00, 1'b0, fr, au, pe, 1'b0, op, of, cl}, (16'h0001 << i) & 16'h0077);
		end
		// Current below, at and beyond the 800 percent ceiling.
		for (int i = 0; i < 4; i++) begin
			@(posedge clock);
			cur <= (i == 0) ? 16'h0000 : (i == 1) ? 16'h0320 : (i == 2) ? 16'h0321 : 16'hFFFF;
			settle();
			chk16(mw1, (i == 0) ? 16'h0000 : 16'h0320);
		end
		// Every mix of fault configuration, fault level and command bit.
		for (int k = 0; k < 16; k++) begin
			@(posedge clock);
			{do2f, auxf, fa} <= 3'(k >> 1);
			cmd1 <= k[0] ? 8'h90 : 8'h6F;
			settle();
			chk1(do2, k[3] ? k[1] : k[0]);
			chk1(aux, k[2] ? k[1] : k[0]);
		end
		// Each agreement outcome, with FF standing for a blank address on either side.
		acase(8'hFF, 8'hFF, 1'b0, 1'b0, 1'b0, 8'hFF, 8'hFF, 0);
		acase(8'h05, 8'hFF, 1'b0, 1'b1, 1'b0, 8'h05, 8'h05, 0);
		acase(8'h05, 8'hFF, 1'b1, 1'b1, 1'b0, 8'h05, 8'h05, 0);
		acase(8'hFF, 8'h07, 1'b1, 1'b1, 1'b0, 8'h07, 8'h07, 1);
		acase(8'h09, 8'h09, 1'b1, 1'b1, 1'b0, 8'h09, 8'h09, 0);
		acase(8'h00, 8'h00, 1'b1, 1'b1, 1'b0, 8'h00, 8'h00, 0);
		acase(8'h0A, 8'h0B, 1'b0, 1'b1, 1'b0, 8'h0A, 8'h0A, 0);
		acase(8'h0A, 8'h0B, 1'b1, 1'b0, 1'b1, 8'h0A, 8'h0B, 0);
		// The panel fix adopts the plug address and starts the bus.
		@(posedge clock);
		fix <= 1'b1;
		@(posedge clock);
		fix <= 1'b0;
		repeat (2) settle();
		chk1(bus, 1'b1);
		chk1(afault, 1'b0);
		chk16({8'h00, caddr}, 16'h000B);
		chk16(16'(nv_count), 16'h0001);
		// A new panel address while running restarts the agreement.
		@(posedge clock);
		chk <= 1'b0;
		paddr <= 8'h22;
		pwr <= 1'b1;
		@(posedge clock);
		pwr <= 1'b0;
		repeat (6) settle();
		chk16({8'h00, caddr, plug_addr}, 16'h2222);
		chk1(bus, 1'b1);
		// Pulling the plug stops the bus; putting it back agrees again on equal addresses.
		@(posedge clock);
		attach <= 1'b0;
		repeat (2) settle();
		chk1(bus, 1'b0);
		@(posedge clock);
		attach <= 1'b1;
		repeat (4) settle();
		chk1(bus, 1'b1);
		chk16({8'h00, caddr, plug_addr}, 16'h2222);
		// A panel entry during an address fault clears it and agrees afresh.
		acase(8'h0A, 8'h0B, 1'b1, 1'b0, 1'b1, 8'h0A, 8'h0B, 0);
		@(posedge clock);
		paddr <= 8'h0B;
		pwr <= 1'b1;
		@(posedge clock);
		pwr <= 1'b0;
		repeat (4) settle();
		chk1(afault, 1'b0);
		chk1(bus, 1'b1);
		chk16({8'h00, caddr}, 16'h000B);
		chk16(16'(nv_count), 16'h0001);
		results();
	end
endmodule : test_actuator_bus_telegram_address_sync
